// ---- design/bgdd_channel.v ----
// One channel of gate-drive decode: pulse decode, dead time, three-state.
`timescale 1ns/1ps
`default_nettype none
`include "bgdd_regs.vh"
module bgdd_channel #(
   parameter CNT_W = `BGDD_CNT_W,
   parameter [CNT_W-1:0] DEAD_CYCLES = `BGDD_DEAD_CYCLES,
   parameter [CNT_W-1:0] HOLDOFF_CYCLES = `BGDD_HOLDOFF_CYCLES
) (
   input wire sys_clk,
   input wire rst_n,
   input wire pulse_high,
   input wire pulse_low,
   input wire rectifier_enable,
   output reg high_side_switch_ff,
   output reg low_side_switch_ff,
   output reg tristate_ff
);
   localparam [1:0] ST_OFF = 2'd0;
   localparam [1:0] ST_HS = 2'd1;
   localparam [1:0] ST_LS = 2'd2;
   localparam [1:0] ST_DEAD = 2'd3;

   reg [1:0] state_ff;
   reg [1:0] nxt_state;
   reg [CNT_W-1:0] dead_cnt_ff;
   reg [CNT_W-1:0] nxt_dead_cnt;
   reg [CNT_W-1:0] hold_cnt_ff;
   reg [CNT_W-1:0] nxt_hold_cnt;
   reg nxt_tristate;
   reg want_hs_ff;
   reg nxt_want_hs;
   reg nxt_hs;
   reg nxt_ls;
   wire mid_band;

   // ***************************************************************
   // Three-state detection
   // ***************************************************************
   assign mid_band = ~pulse_high & ~pulse_low;

   always @* begin
      nxt_hold_cnt = hold_cnt_ff;
      nxt_tristate = tristate_ff;
      if (!mid_band) begin
         nxt_hold_cnt = {CNT_W{1'b0}};
         nxt_tristate = 1'b0;
      end else if (hold_cnt_ff >= HOLDOFF_CYCLES) begin
         nxt_tristate = 1'b1;
      end else begin
         nxt_hold_cnt = hold_cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end

   // ***************************************************************
   // Switch sequencing
   // ***************************************************************
   // Every exit from ST_HS or ST_LS outside three-state passes through ST_DEAD with both off;
   // entry to three-state goes straight to ST_OFF and skips the dead time.
   always @* begin
      nxt_state = state_ff;
      nxt_dead_cnt = dead_cnt_ff;
      nxt_want_hs = want_hs_ff;
      if (nxt_tristate) begin
         nxt_state = ST_OFF;
      end else if (pulse_high) begin
         nxt_want_hs = 1'b1;
      end else if (pulse_low) begin
         nxt_want_hs = 1'b0;
      end
      if (!nxt_tristate) begin
         case (state_ff)
            ST_HS: begin
               if (!nxt_want_hs) begin
                  nxt_state = ST_DEAD;
                  nxt_dead_cnt = {CNT_W{1'b0}};
               end
            end
            ST_LS: begin
               if (nxt_want_hs || !rectifier_enable) begin
                  nxt_state = ST_DEAD;
                  nxt_dead_cnt = {CNT_W{1'b0}};
               end
            end
            ST_DEAD: begin
               if (dead_cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1} >= DEAD_CYCLES)
               begin
                  nxt_state = ST_OFF;
               end else begin
                  nxt_dead_cnt = dead_cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
               end
            end
            default: begin
               if (mid_band) begin
                  nxt_state = ST_OFF;
               end else if (nxt_want_hs) begin
                  nxt_state = ST_HS;
               end else if (rectifier_enable) begin
                  nxt_state = ST_LS;
               end
            end
         endcase
      end
      nxt_hs = (nxt_state == ST_HS);
      nxt_ls = (nxt_state == ST_LS) & rectifier_enable;
   end

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= ST_OFF;
         dead_cnt_ff <= {CNT_W{1'b0}};
         hold_cnt_ff <= {CNT_W{1'b0}};
         tristate_ff <= 1'b0;
         want_hs_ff <= 1'b0;
         high_side_switch_ff <= 1'b0;
         low_side_switch_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         dead_cnt_ff <= nxt_dead_cnt;
         hold_cnt_ff <= nxt_hold_cnt;
         tristate_ff <= nxt_tristate;
         want_hs_ff <= nxt_want_hs;
         high_side_switch_ff <= nxt_hs;
         low_side_switch_ff <= nxt_ls;
      end
   end
endmodule // bgdd_channel
`default_nettype wire

// ---- shared/bgdd_regs.vh ----
// Timing constants for the dual buck gate-drive decode block.
`ifndef BGDD_REGS_VH
`define BGDD_REGS_VH
// Internal clock period in ns.
`define BGDD_CLK_PERIOD_NS 10
// Dead time between one switch turning off and the other turning on, ns.
`define BGDD_DEAD_TIME_NS 20
// Dead time in cycles, least time rounded up.
`define BGDD_DEAD_CYCLES \
   ((`BGDD_DEAD_TIME_NS + `BGDD_CLK_PERIOD_NS - 1) / `BGDD_CLK_PERIOD_NS)
// Three-state hold-off time, ns.
`define BGDD_HOLDOFF_TIME_NS 200
// Hold-off in cycles, least time rounded up.
`define BGDD_HOLDOFF_CYCLES \
   ((`BGDD_HOLDOFF_TIME_NS + `BGDD_CLK_PERIOD_NS - 1) / `BGDD_CLK_PERIOD_NS)
// Width of the per-channel timers.
`define BGDD_CNT_W 8
`endif

// ---- design/bgdd_top.v ----
// Dual-channel buck gate-drive decode top: reset and input sync, channels.
`timescale 1ns/1ps
`default_nettype none
`include "bgdd_regs.vh"
module bgdd_top #(
   parameter CNT_W = `BGDD_CNT_W,
   parameter [CNT_W-1:0] DEAD_CYCLES = `BGDD_DEAD_CYCLES,
   parameter [CNT_W-1:0] HOLDOFF_CYCLES = `BGDD_HOLDOFF_CYCLES
) (
   input wire sys_clk,
   input wire arst_n,
   input wire [1:0] pulse_high,
   input wire [1:0] pulse_low,
   input wire [1:0] rectifier_enable,
   output wire [1:0] high_side_switch,
   output wire [1:0] low_side_switch,
   output wire [1:0] tristate
);
   // ***************************************************************
   // Reset release
   // ***************************************************************
   reg [1:0] rst_sync_ff;
   wire rst_n;

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync_ff <= 2'b00;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_ff[1];

   // ***************************************************************
   // Channels
   // ***************************************************************
   // Pins are asynchronous to the internal clock, so each passes two
   // flip-flops; only the second stage reaches the channel logic.
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
         reg [2:0] meta_ff;
         reg [2:0] sync_ff;
         always @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               meta_ff <= 3'b000;
               sync_ff <= 3'b000;
            end else begin
               meta_ff <= {rectifier_enable[ch], pulse_low[ch],
                           pulse_high[ch]};
               sync_ff <= meta_ff;
            end
         end
         bgdd_channel #(
            .CNT_W(CNT_W),
            .DEAD_CYCLES(DEAD_CYCLES),
            .HOLDOFF_CYCLES(HOLDOFF_CYCLES)
         ) u_chan (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .pulse_high(sync_ff[0]),
            .pulse_low(sync_ff[1]),
            .rectifier_enable(sync_ff[2]),
            .high_side_switch_ff(high_side_switch[ch]),
            .low_side_switch_ff(low_side_switch[ch]),
            .tristate_ff(tristate[ch])
         );
      end
   endgenerate
endmodule // bgdd_top
`default_nettype wire

// ---- tb/bgdd_ctrl_model.sv ----
// Controller model driving pulse levels and rectifier enables.
`timescale 1ns/1ps
`default_nettype none
module bgdd_ctrl_model (
   input wire logic sys_clk,
   input wire logic [3:0] cmd,
   input wire logic [1:0] en,
   output logic [1:0] ph,
   output logic [1:0] pl,
   output logic [1:0] re
);
   // Per channel cmd: 0 low, 1 high, 2 mid band.
   always @(posedge sys_clk) begin
      ph <= {cmd[3:2] == 2'h1, cmd[1:0] == 2'h1};
      pl <= {cmd[3:2] == 2'h0, cmd[1:0] == 2'h0};
      re <= en;
   end
endmodule // bgdd_ctrl_model
`default_nettype wire

// ---- tb/bgdd_properties.sv ----
// Port-level checks for the gate-drive decode top.
`timescale 1ns/1ps
`default_nettype none
module bgdd_properties #(parameter HOLDOFF_CYCLES = 20) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic [1:0] pulse_high,
   input wire logic [1:0] pulse_low,
   input wire logic [1:0] rectifier_enable,
   input wire logic [1:0] high_side_switch,
   input wire logic [1:0] low_side_switch,
   input wire logic [1:0] tristate
);
   localparam int TS_WAIT = HOLDOFF_CYCLES + 8;
   wire band = !pulse_high[0] && !pulse_low[0];
   logic [5:0] band_ff;
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) band_ff <= 6'h00;
      else if (!band) band_ff <= 6'h00;
      else if (band_ff != 6'h3f) band_ff <= band_ff + 6'h01;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   a_no_overlap: assert property (!(high_side_switch & low_side_switch))
      else $error("overlap");
   a_dead_gap: assert property ($fell(low_side_switch[0]) |->
      !high_side_switch[0] [*2]) else $error("dead gap");
   a_ls_disabled: assert property (!rectifier_enable[0] [*4] |->
      !low_side_switch[0]) else $error("low side on");
   a_hs_follows: assert property (pulse_high[0] [*8] |->
      high_side_switch[0] && !low_side_switch[0]) else $error("hs");
   a_ls_follows: assert property (
      (pulse_low[0] && rectifier_enable[0]) [*8] |-> low_side_switch[0] &&
      !high_side_switch[0]) else $error("ls");
   a_band_off: assert property (band_ff >= TS_WAIT |-> tristate[0] &&
      !high_side_switch[0] && !low_side_switch[0]) else $error("band");
   a_ts_cause: assert property ($rose(tristate[0]) |-> $past(band) &&
      $past(band, 5)) else $error("tristate");
   a_chan_b: assert property (pulse_high[1] [*8] |->
      high_side_switch[1]) else $error("channel b");
   c_ts: cover property ($rose(tristate[0]));
   c_swap: cover property ($fell(low_side_switch[0]) ##3 high_side_switch[0]);
   c_b: cover property ($rose(high_side_switch[1]));
endmodule // bgdd_properties
bind bgdd_top bgdd_properties #(.HOLDOFF_CYCLES(HOLDOFF_CYCLES)) chk_u (
   .sys_clk(sys_clk), .arst_n(arst_n), .pulse_high(pulse_high),
   .pulse_low(pulse_low), .rectifier_enable(rectifier_enable),
   .high_side_switch(high_side_switch), .low_side_switch(low_side_switch),
   .tristate(tristate));
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the dual gate-drive decode top.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [3:0] cmd = 4'h0;
   logic [1:0] en = 2'h0;
   wire [1:0] ph, pl, re, hs, ls, ts;
   int fail_count = 0;
   int check_count = 0;
   always #5 sys_clk = ~sys_clk;
   bgdd_ctrl_model ctl_u (.sys_clk(sys_clk), .cmd(cmd), .en(en), .ph(ph),
      .pl(pl), .re(re));
   bgdd_top #(.DEAD_CYCLES(8'h02), .HOLDOFF_CYCLES(8'h04)) dut_u (
      .sys_clk(sys_clk), .arst_n(arst_n), .pulse_high(ph), .pulse_low(pl),
      .rectifier_enable(re), .high_side_switch(hs), .low_side_switch(ls),
      .tristate(ts));
   task automatic chk(input logic [5:0] got, input logic [5:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %0t: %h not %h", $time, got, exp);
      end
   endtask
   // Holding each level 30 cycles keeps the pulse rate legal.
   task automatic go(input logic [3:0] c, input logic [1:0] e, input int n);
      @(posedge sys_clk);
      cmd <= c;
      en <= e;
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic t_sync();
      int gap;
      gap = 0;
      go(4'h0, 2'h3, 30);
      chk({ts, ls, hs}, 6'h0c);
      go(4'h1, 2'h3, 0);
      repeat (30) begin
         @(posedge sys_clk);
         #1;
         if (ls[0] === 1'b0 && hs[0] === 1'b0) gap++;
      end
      chk({ts, ls, hs}, 6'h09);
      // Two dead cycles plus the idle cycle that picks the next switch.
      chk(6'(gap), 6'h03);
   endtask
   task automatic t_nosync();
      go(4'h5, 2'h0, 30);
      chk({ts, ls, hs}, 6'h03);
      go(4'h0, 2'h0, 30);
      chk({ts, ls, hs}, 6'h00);
   endtask
   task automatic t_tri();
      go(4'h0, 2'h3, 30);
      // Three edges reach the channel, then hold-off ends one edge late.
      go(4'h2, 2'h3, 7);
      chk({ts, ls, hs}, 6'h0c);
      @(posedge sys_clk);
      #1;
      chk({ts, ls, hs}, 6'h18);
      for (int e = 0; e < 4; e += 3) begin
         go(4'ha, 2'(e), 30);
         chk({ts, ls, hs}, 6'h30);
         go(4'h0, 2'h3, 30);
         chk({ts, ls, hs}, 6'h0c);
      end
   endtask
   task automatic t_reset();
      @(posedge sys_clk);
      arst_n <= 1'b0;
      repeat (6) @(posedge sys_clk);
      #1;
      chk({ts, ls, hs}, 6'h00);
      @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      #1;
      chk({ts, ls, hs}, 6'h00);
      go(4'h0, 2'h3, 10);
      chk({ts, ls, hs}, 6'h0c);
   endtask
   task automatic test_done();
      if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge sys_clk);
      arst_n <= 1'b1;
      t_sync();
      t_nosync();
      t_tri();
      t_reset();
      test_done();
   end
   initial begin
      repeat (3000) @(posedge sys_clk);
      fail_count++;
      test_done();
   end
endmodule // tb_top
`default_nettype wire
